/* include/tlgc_defines.vh */
// Register map, field positions, reset values and limits of the trigger length gate controller
`ifndef TLGC_DEFINES_VH
`define TLGC_DEFINES_VH
// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define TLGC_OFS_CTRL 6'h00
`define TLGC_OFS_COUNT 6'h04
`define TLGC_OFS_OFFSET 6'h08
`define TLGC_OFS_LENGTH 6'h0C
`define TLGC_OFS_OUTVAL 6'h10
`define TLGC_OFS_TEMP 6'h14
`define TLGC_OFS_STATUS 6'h18
`define TLGC_OFS_IRQ_STAT 6'h1C
`define TLGC_OFS_IRQ_MASK 6'h20
// ------------------------------------------------------------
// Control fields
// ------------------------------------------------------------
`define TLGC_CTRL_TRIG_LSB 0
`define TLGC_CTRL_TRACK_LSB 4
`define TLGC_CTRL_SEL_BIT 8
`define TLGC_CTRL_SYNC_BIT 9
// ------------------------------------------------------------
// Values and limits
// ------------------------------------------------------------
`define TLGC_TRIG_HIGH 3'h0
`define TLGC_TRIG_LOW 3'h1
`define TLGC_TRIG_RISE 3'h2
`define TLGC_TRIG_FALL 3'h3
`define TLGC_TRIG_AND 3'h4
`define TLGC_TRIG_ANDINV 3'h5
`define TLGC_TRIG_MAX 3'h5
`define TLGC_TRACK_MAX 3'h6
`define TLGC_TRACK_RST 3'h2
`define TLGC_TEMP_LIMIT 8'h4B
// Interrupt bits
`define TLGC_IRQ_START 0
`define TLGC_IRQ_STOP 1
`define TLGC_IRQ_TEMP 2
`endif

/* rtl/tlgc_trigger_length_gate.v */
// Trigger length gate controller with Avalon-MM register slave
// ------------------------------------------------------------
// Summary of operation
// R1: Trigger types zero to five, fixed order
// R2: Every trigger event counts object once
// R3: Level types: gate open during active level
// R4: Edge types: edge stops and restarts measurement
// R5: Synced output refreshes on trigger stop
// R6: AND start: start rises, stop high, armed
// R7: AND stop: stop falls while start high
// R8: Reverse passage and other paths: no action
// R9: Single barrier never starts a measurement
// R10: Inverted AND uses inverted levels
// R11: Objects longer than spacing, stop to start
// R12: Barrier offset added to delivered length
// R13: Over-temperature error above 75 degrees
// R14: Tracking mode zero to six, reset two
// R15: Object counter loadable, readable, resets zero
// R16: Select setting makes standby second trigger
// R17: Inputs synchronised, one pulse per edge
// ------------------------------------------------------------
//
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`include "tlgc_defines.vh"
module tlgc_trigger_length_gate #(
   parameter LEN_W = 32
)(
   input wire core_clk,
   input wire rst_n,
   input wire stop_barrier_input,
   input wire start_barrier_input,
   input wire standby_input,
   input wire length_tick,
   input wire [7:0] temperature,
   input wire [31:0] meas_value,
   input wire [5:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output wire avs_waitrequest,
   output wire measuring,
   output wire trigger_event,
   output reg over_temperature_error,
   output reg [31:0] out_channel_value,
   output wire irq
);
   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   reg [2:0] sync1_r;
   reg [2:0] sync2_r;
   reg [2:0] prev_r;
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync1_r <= 3'h0;
         sync2_r <= 3'h0;
         prev_r <= 3'h0;
      end
      else
      begin
         sync1_r <= {standby_input, start_barrier_input, stop_barrier_input}; // [R17]
         sync2_r <= sync1_r; // [R17]
         prev_r <= sync2_r;
      end
   end
   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   reg [2:0] trig_type_r;
   reg [2:0] track_r;
   reg sel_r;
   reg sync_r;
   reg [15:0] count_r;
   reg [31:0] offset_r;
   reg [LEN_W-1:0] len_acc_r;
   reg [31:0] len_out_r;
   reg [2:0] irq_stat_r;
   reg [2:0] irq_mask_r;
   reg meas_r;
   reg [1:0] and_st_r;
   reg rd_done_r;
   // Second trigger from standby when selected
   wire start_lvl = sel_r ? sync2_r[2] : sync2_r[1]; // [R16]
   wire start_prv = sel_r ? prev_r[2] : prev_r[1]; // [R16]
   wire stop_lvl = sync2_r[0];
   wire stop_prv = prev_r[0];
   wire inv = (trig_type_r == `TLGC_TRIG_ANDINV); // [R10]
   wire a_stop = stop_lvl ^ inv; // [R10]
   wire a_stop_p = stop_prv ^ inv;
   wire a_start = start_lvl ^ inv;
   wire a_start_p = start_prv ^ inv;
   wire rise = stop_lvl & ~stop_prv; // [R17]
   wire fall = ~stop_lvl & stop_prv; // [R17]
   // ------------------------------------------------------------
   // Trigger decode
   // ------------------------------------------------------------
   localparam ST_IDLE = 2'h0;
   localparam ST_ARMED = 2'h1;
   localparam ST_RUN = 2'h2;
   reg start_ev;
   reg stop_ev;
   reg [1:0] and_nxt;
   always @*
   begin
      start_ev = 1'b0;
      stop_ev = 1'b0;
      and_nxt = and_st_r;
      case (trig_type_r) // [R1]
         `TLGC_TRIG_HIGH:
         begin
            start_ev = rise; // [R3]
            stop_ev = fall & meas_r; // [R3]
         end
         `TLGC_TRIG_LOW:
         begin
            start_ev = fall; // [R3]
            stop_ev = rise & meas_r; // [R3]
         end
         `TLGC_TRIG_RISE:
         begin
            start_ev = rise; // [R4]
            stop_ev = rise; // [R4]
         end
         `TLGC_TRIG_FALL:
         begin
            start_ev = fall; // [R4]
            stop_ev = fall; // [R4]
         end
         `TLGC_TRIG_AND, `TLGC_TRIG_ANDINV:
         begin
            case (and_st_r)
               ST_IDLE:
                  if (a_stop & ~a_start)
                     and_nxt = ST_ARMED; // [R9]
               ST_ARMED:
                  if (a_stop & a_start & ~a_start_p & a_stop_p)
                  begin
                     and_nxt = ST_RUN;
                     start_ev = 1'b1; // [R6]
                  end
                  else if (~a_stop | a_start)
                     and_nxt = ST_IDLE; // [R8]
               ST_RUN:
                  if (~a_stop & a_stop_p & a_start)
                  begin
                     and_nxt = ST_IDLE;
                     stop_ev = 1'b1; // [R7]
                  end
                  else if (~a_start)
                     and_nxt = ST_IDLE; // [R8]
               default:
                  and_nxt = ST_IDLE;
            endcase
         end
         default:
            and_nxt = ST_IDLE;
      endcase
   end
   assign trigger_event = start_ev | stop_ev;
   assign measuring = meas_r;
   // ------------------------------------------------------------
   // Bus slave
   // ------------------------------------------------------------
   assign avs_waitrequest = avs_read & ~rd_done_r;
   // Register address match
   function reg_hit;
      input [5:0] addr;
      input [5:0] ofs;
      begin
         reg_hit = (addr == ofs);
      end
   endfunction
   wire wr = avs_write & avs_byteenable[0];
   wire wr_ctrl = wr & reg_hit(avs_address, `TLGC_OFS_CTRL);
   wire wr_cnt = wr & reg_hit(avs_address, `TLGC_OFS_COUNT);
   wire wr_ofs = wr & reg_hit(avs_address, `TLGC_OFS_OFFSET);
   wire wr_stat = wr & reg_hit(avs_address, `TLGC_OFS_IRQ_STAT);
   wire wr_mask = wr & reg_hit(avs_address, `TLGC_OFS_IRQ_MASK);
   // Over-temperature event only on the crossing
   wire ovt_rise = (temperature > `TLGC_TEMP_LIMIT) & ~over_temperature_error; // [R13]
   wire [2:0] ev = {ovt_rise, stop_ev, start_ev};
   reg [31:0] rd_nxt;
   always @*
   begin
      case (avs_address)
         `TLGC_OFS_CTRL: rd_nxt = {22'h0, sync_r, sel_r, 1'b0, track_r, 1'b0, trig_type_r};
         `TLGC_OFS_COUNT: rd_nxt = {16'h0, count_r}; // [R15]
         `TLGC_OFS_OFFSET: rd_nxt = offset_r;
         `TLGC_OFS_LENGTH: rd_nxt = len_out_r;
         `TLGC_OFS_OUTVAL: rd_nxt = out_channel_value;
         `TLGC_OFS_TEMP: rd_nxt = {24'h0, temperature};
         `TLGC_OFS_STATUS: rd_nxt = {28'h0, over_temperature_error, and_st_r, meas_r};
         `TLGC_OFS_IRQ_STAT: rd_nxt = {29'h0, irq_stat_r};
         `TLGC_OFS_IRQ_MASK: rd_nxt = {29'h0, irq_mask_r};
         default: rd_nxt = 32'h0;
      endcase
   end
   assign irq = |(irq_stat_r & irq_mask_r);
   // ------------------------------------------------------------
   // Read handshake
   // ------------------------------------------------------------
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_done_r <= 1'b0;
         avs_readdata <= 32'h0;
      end
      else
      begin
         rd_done_r <= avs_read & ~rd_done_r;
         if (avs_read & ~rd_done_r)
            avs_readdata <= rd_nxt;
      end
   end
   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         trig_type_r <= `TLGC_TRIG_HIGH;
         track_r <= `TLGC_TRACK_RST; // [R14]
         sel_r <= 1'b0;
         sync_r <= 1'b0;
         offset_r <= 32'h0;
         irq_mask_r <= 3'h0;
      end
      else
      begin
         if (wr_ctrl)
         begin
            if (avs_writedata[2:0] <= `TLGC_TRIG_MAX)
               trig_type_r <= avs_writedata[2:0]; // [R1]
            if (avs_writedata[6:4] <= `TLGC_TRACK_MAX)
               track_r <= avs_writedata[6:4]; // [R14]
            sel_r <= avs_writedata[`TLGC_CTRL_SEL_BIT]; // [R16]
            sync_r <= avs_writedata[`TLGC_CTRL_SYNC_BIT]; // [R5]
         end
         if (wr_ofs)
            offset_r <= avs_writedata; // [R12]
         if (wr_mask)
            irq_mask_r <= avs_writedata[2:0];
      end
   end
   // ------------------------------------------------------------
   // Over-temperature flag and interrupt status
   // ------------------------------------------------------------
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         over_temperature_error <= 1'b0;
         irq_stat_r <= 3'h0;
      end
      else
      begin
         over_temperature_error <= (temperature > `TLGC_TEMP_LIMIT); // [R13]
         // Set wins over a clear in the same cycle
         irq_stat_r <= (irq_stat_r & ~(wr_stat ? avs_writedata[2:0] : 3'h0)) | ev;
      end
   end
   // ------------------------------------------------------------
   // Object counter
   // ------------------------------------------------------------
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         count_r <= 16'h0; // [R15]
      else if (start_ev | stop_ev)
         count_r <= count_r + 16'h1; // [R2]
      else if (wr_cnt)
         count_r <= avs_writedata[15:0]; // [R15]
   end
   // ------------------------------------------------------------
   // Length gate and accumulator
   // ------------------------------------------------------------
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         and_st_r <= ST_IDLE;
         meas_r <= 1'b0;
         len_acc_r <= {LEN_W{1'b0}};
      end
      else
      begin
         and_st_r <= and_nxt;
         if (start_ev)
            meas_r <= 1'b1;
         else if (stop_ev)
            meas_r <= 1'b0;
         if (start_ev)
            len_acc_r <= {LEN_W{1'b0}}; // [R4]
         else if (meas_r & length_tick)
            len_acc_r <= len_acc_r + {{(LEN_W-1){1'b0}}, 1'b1};
      end
   end
   // ------------------------------------------------------------
   // Length result and output channel
   // ------------------------------------------------------------
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         len_out_r <= 32'h0;
         out_channel_value <= 32'h0;
      end
      else if (stop_ev)
      begin
         len_out_r <= len_acc_r[31:0] + offset_r; // [R12]
         if (sync_r)
            out_channel_value <= meas_value; // [R5]
      end
   end
endmodule

/* testbench/tlgc_checker_assertions.sv */
// Concurrent checks on the gate controller ports
module tlgc_checker (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic [31:0] avs_readdata,
   input wire logic [7:0] temperature,
   input wire logic over_temperature_error,
   input wire logic trigger_event,
   input wire logic measuring
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   chk_ovt_limit: assert property ($past(rst_n) |-> over_temperature_error == ($past(temperature) > 8'h4B))
      else $error("over-temperature flag wrong");
   chk_read_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("read wait state wrong");
   chk_write_nowait: assert property (avs_write |-> !avs_waitrequest)
      else $error("write stalled");
   chk_wait_cause: assert property (avs_waitrequest |-> avs_read && !$past(avs_waitrequest))
      else $error("stray wait state");
   chk_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
      else $error("read data moved");
   chk_event_pulse: assert property (trigger_event |=> !trigger_event)
      else $error("event longer than one cycle");
   chk_start_cause: assert property ($rose(measuring) |-> $past(trigger_event))
      else $error("start without event");
   chk_stop_cause: assert property ($fell(measuring) |-> $past(trigger_event))
      else $error("stop without event");
endmodule
bind tlgc_trigger_length_gate tlgc_checker chk_i (.core_clk(core_clk), .rst_n(rst_n), .avs_read(avs_read),
   .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata), .temperature(temperature),
   .over_temperature_error(over_temperature_error), .trigger_event(trigger_event), .measuring(measuring));

/* testbench/tlgc_barrier_model.sv */
// Two light barrier model driving the trigger inputs
module tlgc_barrier_model (
   input wire logic core_clk,
   output logic stop_barrier_input = 1'b0,
   output logic start_barrier_input = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   // Drive both levels, then let them settle
   task automatic put(input logic sp, input logic st);
      @(posedge core_clk);
      stop_barrier_input <= sp;
      start_barrier_input <= st;
      repeat (6) @(posedge core_clk);
   endtask
   // Object longer than spacing, forward runs stop side first
   task automatic pass(input logic inv, input logic fwd);
      put(inv ^ fwd, inv ^ !fwd); // First barrier
      put(!inv, !inv); // Both covered
      put(inv ^ !fwd, inv ^ fwd);
      put(inv, inv);
   endtask
endmodule

/* testbench/trigger_length_gate_controller_test.sv */
// Self-checking bench for the trigger length gate controller
`include "tlgc_defines.vh"
module trigger_length_gate_controller_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic length_tick = 1'b0;
   logic [7:0] temperature = 8'h14;
   logic [31:0] meas_value = 32'h0;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, out_channel_value, q, c0;
   logic avs_waitrequest, measuring, trigger_event, over_temperature_error, irq, stop_b, start_b;
   logic stby_on = 1'b0;
   int failures = 0;
   int n_checks = 0;
   int n_evt = 0;
   int e0;
   tlgc_trigger_length_gate uut (.core_clk(core_clk), .rst_n(rst_n), .stop_barrier_input(stop_b),
      .start_barrier_input(start_b & ~stby_on), .standby_input(start_b & stby_on), .length_tick(length_tick),
      .temperature(temperature),
      .meas_value(meas_value), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .measuring(measuring), .trigger_event(trigger_event),
      .over_temperature_error(over_temperature_error), .out_channel_value(out_channel_value), .irq(irq));
   tlgc_barrier_model bar (.core_clk(core_clk), .stop_barrier_input(stop_b), .start_barrier_input(start_b));
   always #10 core_clk = ~core_clk;
   always @(posedge core_clk)
      if (trigger_event === 1'b1)
         n_evt <= n_evt + 1;
   task automatic final_report;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 20);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n >= 20)
      begin
         failures++;
         final_report();
      end
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   task automatic snap;
      bus(1'b0, `TLGC_OFS_COUNT, 32'h0);
      c0 = q;
      e0 = n_evt;
   endtask
   task automatic cnt(input int d);
      bus(1'b0, `TLGC_OFS_COUNT, 32'h0);
      chk((q - c0) & 32'hFFFF, d);
      chk(n_evt - e0, d);
   endtask
   task automatic t_regs;
      rd(`TLGC_OFS_CTRL, 32'h20); // Reset value
      rd(`TLGC_OFS_COUNT, 32'h0); // Cleared
      bus(1'b1, `TLGC_OFS_CTRL, 32'h76);
      rd(`TLGC_OFS_CTRL, 32'h20); // Out of range kept
      bus(1'b1, `TLGC_OFS_CTRL, 32'h65);
      rd(`TLGC_OFS_CTRL, 32'h65); // Top values
      bus(1'b1, `TLGC_OFS_COUNT, 32'hFFFF);
      rd(`TLGC_OFS_COUNT, 32'hFFFF); // Loaded
      rd(6'h3C, 32'h0);
      bus(1'b1, `TLGC_OFS_OFFSET, 32'h10);
   endtask
   task automatic t_level(input logic [2:0] m);
      bus(1'b1, `TLGC_OFS_CTRL, 32'h220 + m);
      bar.put(m[0], 1'b0);
      snap();
      bar.put(!m[0], 1'b0);
      chk(measuring, 1); // Gate open
      length_tick <= 1'b1;
      repeat (3) @(posedge core_clk);
      length_tick <= 1'b0;
      meas_value <= 32'hA5A50000 + m;
      bar.put(m[0], 1'b0);
      chk(measuring, 0); // Gate closed
      chk(out_channel_value, 32'hA5A50000 + m); // Refresh on stop
      rd(`TLGC_OFS_LENGTH, 32'h13); // Offset added
      cnt(2); // Start and stop counted
   endtask
   task automatic t_and(input logic inv, input logic s);
      stby_on <= s;
      bus(1'b1, `TLGC_OFS_CTRL, 32'h224 + inv + (s ? 32'h100 : 32'h0)); // Inverted variant
      bar.put(inv, inv);
      snap();
      bar.pass(inv, 1'b1);
      cnt(2); // Start then stop
      bar.pass(inv, 1'b0);
      bar.put(!inv, inv);
      bar.put(inv, inv);
      bar.put(inv, !inv);
      bar.put(inv, inv);
      cnt(2); // Reverse and single barrier ignored
   endtask
   task automatic t_edge(input logic [2:0] m);
      bus(1'b1, `TLGC_OFS_CTRL, 32'h220 + m);
      bar.put(m[0], 1'b0);
      snap();
      meas_value <= 32'h5A5A0000 + m;
      bar.put(!m[0], 1'b0);
      bar.put(m[0], 1'b0);
      cnt(1); // One pulse per selected edge
      chk(measuring, 1); // Restarted at once
      chk(out_channel_value, 32'h5A5A0000 + m); // Refresh on edge
   endtask
   task automatic t_irq;
      temperature <= 8'h4B;
      repeat (3) @(posedge core_clk);
      chk(over_temperature_error, 0); // At limit
      temperature <= 8'h4C;
      repeat (3) @(posedge core_clk);
      chk(over_temperature_error, 1); // Above limit
      rd(`TLGC_OFS_IRQ_STAT, 32'h7);
      bus(1'b1, `TLGC_OFS_IRQ_MASK, 32'h7);
      @(posedge core_clk);
      chk(irq, 1);
      bus(1'b1, `TLGC_OFS_IRQ_MASK, 32'h0);
      @(posedge core_clk);
      chk(irq, 0);
      bus(1'b1, `TLGC_OFS_IRQ_STAT, 32'h7);
      rd(`TLGC_OFS_IRQ_STAT, 32'h0);
      bus(1'b1, `TLGC_OFS_IRQ_MASK, 32'h7);
      @(posedge core_clk);
      chk(irq, 0);
   endtask
   initial
   begin
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      t_regs();
      t_level(3'h0); // High level
      t_level(3'h1); // Low level
      t_and(1'b0, 1'b0); // Two barriers
      t_and(1'b1, 1'b0); // Inverted
      t_and(1'b0, 1'b1); // Standby as start barrier
      t_edge(3'h2); // Rising
      t_edge(3'h3); // Falling
      t_irq();
      final_report();
   end
endmodule
